// ==== hw/sarctl_top.sv ====
// Conversion controller: APB registers, trigger selection, clock divider and
// successive-approximation sequencer driving the analog switch controls.
// Assumes the trigger inputs are asynchronous to pclk and the comparator output
// settles within one pclk of a new trial code, since the front end is clocked by pclk.
`timescale 1ns/100ps
module sarctl_top
(
	input wire logic pclk, // APB clock, 25 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error for unmapped address
	input wire logic external_convert_trigger_pin, // External start pin
	input wire logic timer1_trigger, // Timer 1 start pulse
	input wire logic timer0_trigger, // Timer 0 start pulse
	input wire logic pwm_trigger, // PWM start pulse
	input wire logic programmable_logic_trigger, // Programmable logic start
	input wire logic comparator_out, // Comparator, pclk domain: high keeps bit
	output logic positive_input_switch, // High: conversion position
	output logic [1:0] negative_input_switch, // 0 channel, 1 reference, 2 ground
	output logic comparator_balance_switch, // High: switch closed
	output logic [4:0] pos_mux_select, // Positive multiplexer select
	output logic [4:0] neg_mux_select, // Negative multiplexer select
	output logic [1:0] adc_mode, // Conversion mode
	output logic adc_power_on, // Analog power enable
	output logic [11:0] dac_code, // Trial code to charge arrays
	output logic conversion_busy_pin, // High during a conversion
	output logic adc_irq // Level interrupt
);
	import sarctl_pkg::*;

	// ****************************************************************
	// Registers and bus
	// ****************************************************************
	logic [12:0] adc_control_reg, next_control;
	logic [4:0] adc_positive_input_select, next_pos;
	logic [4:0] adc_negative_input_select, next_neg;
	logic [11:0] conversion_result_reg, next_result;
	logic conversion_ready_flag, next_ready;
	logic irq_mask, next_mask;
	logic [4:0] pend_pos, next_pend_pos, pend_neg, next_pend_neg;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic wr, rd, access, conv_done, soft_reset;
	sarctl_state_type state, next_state;

	assign access = psel && penable && !pready;
	assign wr = access && pwrite;
	assign rd = access && !pwrite;
	assign soft_reset = wr && paddr == reset_offset && pwdata == reset_key;

	always_comb
	begin
		next_control = adc_control_reg;
		next_pend_pos = pend_pos;
		next_pend_neg = pend_neg;
		next_mask = irq_mask;
		next_ready = conversion_ready_flag;
		next_prdata = 32'h0000_0000;
		next_pready = access;
		next_pslverr = 1'b0;
		if (wr)
		begin
			case (paddr)
				ctrl_offset: next_control = pwdata[12:0];
				pos_offset: next_pend_pos = pwdata[4:0];
				neg_offset: next_pend_neg = pwdata[4:0];
				irq_stat_offset: if (pwdata[0]) next_ready = 1'b0;
				irq_mask_offset: next_mask = pwdata[0];
				reset_offset: ;
				stat_offset, result_offset: ;
				default: next_pslverr = 1'b1;
			endcase
		end
		if (rd)
		begin
			case (paddr)
				ctrl_offset: next_prdata = {19'h0_0000, adc_control_reg};
				pos_offset: next_prdata = {27'h000_0000, pend_pos};
				neg_offset: next_prdata = {27'h000_0000, pend_neg};
				stat_offset, irq_stat_offset: next_prdata = {31'h0, conversion_ready_flag};
				result_offset:
				begin
					next_prdata = {4'h0, conversion_result_reg, 16'h0000};
					next_ready = 1'b0;
				end
				irq_mask_offset: next_prdata = {31'h0, irq_mask};
				default: next_pslverr = 1'b1;
			endcase
		end
		if (conv_done)
		begin
			next_ready = 1'b1; // set wins over the read clear
			if (adc_control_reg[2:0] == type_single)
				next_control[2:0] = type_pin;
		end
		if (soft_reset)
		begin
			next_control = ctrl_reset;
			next_pend_pos = sel_reset;
			next_pend_neg = sel_reset;
			next_ready = 1'b0;
			next_mask = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			adc_control_reg <= ctrl_reset;
			pend_pos <= sel_reset;
			pend_neg <= sel_reset;
			irq_mask <= 1'b0;
			conversion_ready_flag <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			adc_control_reg <= next_control;
			pend_pos <= next_pend_pos;
			pend_neg <= next_pend_neg;
			irq_mask <= next_mask;
			conversion_ready_flag <= next_ready;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ****************************************************************
	// Input synchronisers and trigger selection
	// ****************************************************************
	logic [4:0] sync1, sync2, sync_prev;
	logic [4:0] raw_in;
	logic [4:0] rise;
	logic trigger, enable;

	assign raw_in = {programmable_logic_trigger, pwm_trigger,
		timer0_trigger, timer1_trigger, external_convert_trigger_pin};
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
			sync_prev <= 5'h00;
		end
		else
		begin
			sync1 <= raw_in;
			sync2 <= sync1;
			sync_prev <= sync2;
		end
	end
	assign rise = sync2 & ~sync_prev;
	assign enable = adc_control_reg[enable_bit] && adc_control_reg[power_bit];

	always_comb
	begin
		case (adc_control_reg[2:0])
			type_pin: trigger = rise[0];
			type_timer1: trigger = rise[1];
			type_timer0: trigger = rise[2];
			type_single: trigger = 1'b1;
			type_continuous: trigger = 1'b1;
			type_logic: trigger = rise[4];
			type_pwm: trigger = rise[3];
			default: trigger = 1'b0;
		endcase
	end

	// ****************************************************************
	// ADC clock divider and conversion sequencer
	// ****************************************************************
	logic [4:0] div_cnt, next_div_cnt, div_limit;
	logic adc_tick;
	logic [4:0] step, next_step, acq_len;
	logic [3:0] bit_idx, next_bit_idx;
	logic [11:0] next_dac;
	logic next_busy;
	logic next_irq;

	always_comb
	begin
		case (adc_control_reg[speed_lsb +: 3])
			3'h0: div_limit = 5'd0;
			3'h1: div_limit = 5'd1;
			3'h2: div_limit = 5'd3;
			3'h3: div_limit = 5'd7;
			3'h4: div_limit = 5'd15;
			default: div_limit = 5'd31;
		endcase
		acq_len = 5'(5'd2 << adc_control_reg[acq_lsb +: 2]);
	end
	assign adc_tick = div_cnt >= div_limit;

	always_comb
	begin
		next_div_cnt = adc_tick ? 5'd0 : 5'(div_cnt + 5'd1);
		next_state = state;
		next_step = step;
		next_bit_idx = bit_idx;
		next_dac = dac_code;
		next_result = conversion_result_reg;
		next_pos = adc_positive_input_select;
		next_neg = adc_negative_input_select;
		conv_done = 1'b0;
		case (state)
			sarctl_idle:
			begin
				next_pos = pend_pos;
				next_neg = pend_neg;
				if (enable && trigger)
				begin
					next_state = sarctl_acquire;
					next_step = 5'd1;
					next_div_cnt = 5'd0;
				end
			end
			sarctl_acquire:
				if (adc_tick)
				begin
					next_step = 5'(step + 5'd1);
					if (step == acq_len)
					begin
						next_state = sarctl_convert;
						next_step = 5'd1;
						next_bit_idx = 4'(result_bits - 1);
						next_dac = 12'h800;
					end
				end
			sarctl_convert:
				if (adc_tick)
				begin
					next_step = 5'(step + 5'd1);
					if (step <= 5'(result_bits))
					begin
						// Keep or drop the trial bit, then try the next one.
						// A synchroniser here would make every trial decide on a stale answer.
						next_dac[bit_idx] = comparator_out;
						if (bit_idx != 4'd0)
						begin
							next_bit_idx = 4'(bit_idx - 4'd1);
							next_dac[bit_idx - 4'd1] = 1'b1;
						end
					end
					if (step == 5'(conv_clocks))
					begin
						next_result = dac_code;
						conv_done = 1'b1;
						next_state = sarctl_idle;
					end
				end
			default: next_state = sarctl_idle;
		endcase
		if (!enable || soft_reset)
			next_state = sarctl_idle;
		next_busy = next_state != sarctl_idle;
		next_irq = next_ready && irq_mask;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= sarctl_idle;
			div_cnt <= 5'd0;
			step <= 5'd0;
			bit_idx <= 4'd0;
			dac_code <= 12'h000;
			conversion_result_reg <= 12'h000;
			adc_positive_input_select <= sel_reset;
			adc_negative_input_select <= sel_reset;
			conversion_busy_pin <= 1'b0;
			adc_irq <= 1'b0;
		end
		else
		begin
			state <= next_state;
			div_cnt <= next_div_cnt;
			step <= next_step;
			bit_idx <= next_bit_idx;
			dac_code <= next_dac;
			conversion_result_reg <= next_result;
			adc_positive_input_select <= next_pos;
			adc_negative_input_select <= next_neg;
			conversion_busy_pin <= next_busy;
			adc_irq <= next_irq;
		end
	end

	// ****************************************************************
	// Switch and multiplexer controls
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			positive_input_switch <= 1'b0;
			negative_input_switch <= 2'd2;
			comparator_balance_switch <= 1'b1;
			pos_mux_select <= sel_reset;
			neg_mux_select <= sel_reset;
			adc_mode <= mode_single_ended;
			adc_power_on <= 1'b0;
		end
		else
		begin
			positive_input_switch <= next_state == sarctl_convert;
			comparator_balance_switch <= next_state != sarctl_convert;
			if (adc_control_reg[mode_lsb +: 2] == mode_single_ended)
				negative_input_switch <= 2'd2;
			else if (adc_control_reg[mode_lsb +: 2] == mode_pseudo)
				negative_input_switch <= next_state == sarctl_convert ? 2'd1 : 2'd0;
			else
				negative_input_switch <= next_state == sarctl_convert ? 2'd1 : 2'd0;
			// Codes 12 and 13 reach the line-driver pins as ordinary selections.
			pos_mux_select <= next_pos;
			neg_mux_select <= next_neg;
			adc_mode <= adc_control_reg[mode_lsb +: 2];
			adc_power_on <= adc_control_reg[power_bit];
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_busy_tracks_state: assert property (@(posedge pclk) disable iff (!presetn)
		conversion_busy_pin == (state != sarctl_idle)) else $error("busy mismatch");
	a_balance_in_acq: assert property (@(posedge pclk) disable iff (!presetn)
		state == sarctl_acquire |-> comparator_balance_switch && !positive_input_switch)
		else $error("acquire switches wrong");
	a_open_in_conv: assert property (@(posedge pclk) disable iff (!presetn)
		state == sarctl_convert |-> !comparator_balance_switch && positive_input_switch)
		else $error("convert switches wrong");
	a_ready_on_done: assert property (@(posedge pclk) disable iff (!presetn)
		conv_done && !soft_reset |=> conversion_ready_flag) else $error("ready not set");
	a_reserved_no_start: assert property (@(posedge pclk) disable iff (!presetn)
		state == sarctl_idle && adc_control_reg[2:0] == 3'h7 |=> state == sarctl_idle)
		else $error("reserved type started");
	a_single_returns: assert property (@(posedge pclk) disable iff (!presetn)
		conv_done && adc_control_reg[2:0] == type_single && !soft_reset
		|=> adc_control_reg[2:0] == type_pin) else $error("single type kept");
	a_se_ground: assert property (@(posedge pclk) disable iff (!presetn)
		adc_mode == mode_single_ended && $stable(adc_mode) |-> negative_input_switch == 2'd2)
		else $error("single-ended not grounded");
	a_sel_stable: assert property (@(posedge pclk) disable iff (!presetn)
		state != sarctl_idle && $past(state) != sarctl_idle |-> $stable(pos_mux_select))
		else $error("mux changed mid conversion");
	a_conv_done_len: assert property (@(posedge pclk) disable iff (!presetn)
		conv_done |-> step == 5'd14) else $error("wrong conversion length");
	c_conversion: cover property (@(posedge pclk) conv_done);
	c_pseudo: cover property (@(posedge pclk) adc_mode == mode_pseudo && state == sarctl_convert);
	c_irq: cover property (@(posedge pclk) adc_irq);
endmodule

// ==== include/sarctl_pkg.sv ====
// Constants, register map and field layout of the SAR converter control block.
// Assumes an APB slave with 32-bit data and a 25 MHz pclk.
// What this block does
// - Type code 100 converts continuously; code 110 converts on each PWM pulse.
// - Positive select: 0-13 external, 16-19 temp, ground, reference, half supply.
// - Negative select: 0-13 external, 16 temp sensor, others reserved.
// - Selections 12 and 13 share line driver transmit pins; expect crosstalk.
// - Acquisition closes balance switch, both input switches at sampling position.
// - Conversion start opens balance switch, input switches move to convert position.
// - Bit trials step through all 12 bits, then conversion completes and code is emitted.
// - Pseudo-differential: negative switch picks channel in acquisition, reference later.
// - Single-ended: negative switch tied to ground throughout.
// - Type field bits 2-0: pin, timer 1, timer 0, single software returning to 000.
// - Conversion lasts 14 ADC clocks plus 2/4/8/16 acquisition; speed divides 1 to 32.
// - Ready bit sets at conversion end, raises interrupt, cleared by reading result.
// - Busy pin is high for the duration of each conversion.
package sarctl_pkg;
	localparam logic [11:0] ctrl_offset = 12'h000;
	localparam logic [11:0] pos_offset = 12'h004;
	localparam logic [11:0] neg_offset = 12'h008;
	localparam logic [11:0] stat_offset = 12'h00c;
	localparam logic [11:0] result_offset = 12'h010;
	localparam logic [11:0] irq_stat_offset = 12'h014;
	localparam logic [11:0] irq_mask_offset = 12'h018;
	localparam logic [11:0] reset_offset = 12'h01c;
	localparam logic [12:0] ctrl_reset = 13'h0_000;
	localparam logic [4:0] sel_reset = 5'h00;
	localparam int type_lsb = 0;
	localparam int mode_lsb = 3;
	localparam int power_bit = 5;
	localparam int enable_bit = 7;
	localparam int acq_lsb = 8;
	localparam int speed_lsb = 10;
	localparam int result_lsb = 16;
	localparam logic [2:0] type_pin = 3'h0;
	localparam logic [2:0] type_timer1 = 3'h1;
	localparam logic [2:0] type_timer0 = 3'h2;
	localparam logic [2:0] type_single = 3'h3;
	localparam logic [2:0] type_continuous = 3'h4;
	localparam logic [2:0] type_logic = 3'h5;
	localparam logic [2:0] type_pwm = 3'h6;
	localparam logic [1:0] mode_single_ended = 2'h0;
	localparam logic [1:0] mode_differential = 2'h1;
	localparam logic [1:0] mode_pseudo = 2'h2;
	localparam logic [4:0] pos_last_external = 5'h0d;
	localparam logic [4:0] pos_first_internal = 5'h10;
	localparam logic [4:0] pos_last_internal = 5'h13;
	localparam logic [4:0] neg_temp_sensor = 5'h10;
	localparam int conv_clocks = 14;
	localparam int result_bits = 12;
	localparam logic [31:0] reset_key = 32'h0000_0001;
	typedef enum logic [1:0] {sarctl_idle, sarctl_acquire, sarctl_convert} sarctl_state_type;
endpackage

// ==== tb/sarctl_analog_model.sv ====
// Behavioural analog front end: sample capacitors and comparator.
// Assumes positive_input_switch high means the arrays hold their charge.
`timescale 1ns/100ps
module sarctl_analog_model
(
	input wire logic pclk, // Bench clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic positive_input_switch, // High: conversion position
	input wire logic [11:0] dac_code, // Trial code from the sequencer
	input wire logic [11:0] level, // Input level presented by the bench
	output logic comparator_out // High: keep trial bit
);
	// ****************************************
	// Sample and compare
	// ****************************************
	logic [11:0] held;
	logic tog;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			held <= 12'h000;
			tog <= 1'b0;
		end
		else
		begin
			tog <= ~tog;
			if (!positive_input_switch) held <= level;
		end
	end
	// Outside a conversion the output toggles so that no stale answer is trusted.
	assign comparator_out = positive_input_switch ? (held >= dac_code) : tog;
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the converter control block.
// Assumes the APB map and switch encodings of the package.
`timescale 1ns/100ps
module tb_top;
	import sarctl_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000, level = 12'h000, dac_code;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r;
	logic pready, pslverr, cmp, psw, bal, busy, irq, adc_power_on;
	logic [4:0] trig = 5'h00, pmux, nmux;
	logic [1:0] nsw, adc_mode, nacq = 2'h2, ncv = 2'h2;
	int err_total = 0, checks_done = 0, bcnt = 0, ccnt = 0, blen = 0, clen = 0, ends = 0;
	always #20 pclk = ~pclk;
	sarctl_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .external_convert_trigger_pin(trig[0]), .timer1_trigger(trig[1]),
		.timer0_trigger(trig[2]), .programmable_logic_trigger(trig[3]),
		.pwm_trigger(trig[4]), .comparator_out(cmp), .positive_input_switch(psw),
		.negative_input_switch(nsw), .comparator_balance_switch(bal), .pos_mux_select(pmux),
		.neg_mux_select(nmux), .adc_mode(adc_mode), .adc_power_on(adc_power_on),
		.dac_code(dac_code), .conversion_busy_pin(busy), .adc_irq(irq));
	sarctl_analog_model model (.pclk(pclk), .presetn(presetn), .positive_input_switch(psw),
		.dac_code(dac_code), .level(level), .comparator_out(cmp));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task stop_test;
		if (err_total == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		r = prdata;
		chk("pslverr", a > reset_offset, pslverr);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Busy length is watched on every rising edge, switch positions on each rising edge while busy is high.
	always @(posedge pclk)
	begin
		if (busy === 1'b1)
		begin
			bcnt <= bcnt + 1;
			if (bal === 1'b1) chk("sw acq", {1'b0, nacq}, {psw, nsw});
			else chk("sw conv", {1'b1, ncv}, {psw, nsw});
			if (bal !== 1'b1) ccnt <= ccnt + 1;
		end
		else if (bcnt != 0)
		begin
			blen <= bcnt;
			clen <= ccnt;
			bcnt <= 0;
			ccnt <= 0;
			ends <= ends + 1;
		end
	end
	function automatic logic [4:0] tmask(input logic [2:0] ty);
		case (ty)
			type_pin: return 5'h01;
			type_timer1: return 5'h02;
			type_timer0: return 5'h04;
			type_logic: return 5'h08;
			type_pwm: return 5'h10;
			default: return 5'h00;
		endcase
	endfunction
	task conv(input logic [2:0] ty, input logic [1:0] md, input logic [1:0] ac, input logic [2:0] sp);
		int n, dv;
		logic m;
		m = 1'($urandom);
		dv = 1 << sp;
		nacq = (md == mode_single_ended) ? 2'h2 : 2'h0;
		ncv = (md == mode_single_ended) ? 2'h2 : 2'h1;
		level <= 12'($urandom);
		apb(1'b1, irq_mask_offset, {31'h0, m});
		apb(1'b1, ctrl_offset, {19'h0, sp, ac, 3'h5, md, ty});
		trig <= tmask(ty);
		n = 0;
		while (busy !== 1'b1 && n < 100)
		begin
			@(posedge pclk);
			n++;
		end
		chk("busy rise", 1, busy);
		chk("mode", md, adc_mode);
		chk("power", 1, adc_power_on);
		n = 0;
		while (busy !== 1'b0 && n < 2000)
		begin
			@(posedge pclk);
			n++;
		end
		trig <= 5'h00;
		repeat (3) @(posedge pclk);
		chk("busy cycles", ((2 << ac) + conv_clocks) * dv, blen);
		chk("conv cycles", conv_clocks * dv, clen);
		chk("irq", m, irq);
		apb(1'b0, stat_offset, 0);
		chk("ready", 1, r);
		apb(1'b0, result_offset, 0);
		chk("result", level, r[27:16]);
		apb(1'b0, stat_offset, 0);
		chk("ready clr", 0, r);
		apb(1'b0, ctrl_offset, 0);
		if (ty == type_single) chk("type back", type_pin, r[2:0]);
		apb(1'b1, irq_stat_offset, 1);
		apb(1'b1, ctrl_offset, 0);
		chk("irq clr", 0, irq);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	logic [2:0] types [6] = '{type_single, type_pin, type_timer1, type_timer0, type_logic, type_pwm};
	logic [4:0] code;
	initial
	begin
		void'($urandom(27487));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("idle sw", 4'b1010, {bal, psw, nsw});
		apb(1'b0, ctrl_offset, 0);
		chk("ctrl rst", 0, r);
		apb(1'b0, 12'h020, 0);
		for (int i = 0; i < 8; i++)
		begin
			code = (i < 2) ? 5'(12 + i) : 5'($urandom % 14);
			if (i > 5) code = pos_first_internal + 5'(i - 6);
			apb(1'b1, pos_offset, {27'h7ff_ffff, code});
			apb(1'b0, pos_offset, 0);
			chk("pos rd", code, r);
			chk("pos mux", code, pmux);
			if (i > 5) code = neg_temp_sensor;
			apb(1'b1, neg_offset, {27'h7ff_ffff, code});
			apb(1'b0, neg_offset, 0);
			chk("neg rd", code, r);
			chk("neg mux", code, nmux);
		end
		apb(1'b1, reset_offset, reset_key);
		apb(1'b0, pos_offset, 0);
		chk("soft rst", 0, r);
		foreach (types[i]) conv(types[i], 2'(i % 3), 2'($urandom), 3'($urandom % 2));
		conv(type_single, mode_pseudo, 2'h3, 3'h5);
		for (int k = 0; k < 2; k++)
		begin
			nacq = 2'h2;
			ncv = 2'h2;
			ends = 0;
			apb(1'b1, ctrl_offset, {29'h0000_0014, k ? 3'h7 : type_continuous});
			repeat (100) @(posedge pclk);
			apb(1'b1, ctrl_offset, 0);
			repeat (40) @(posedge pclk);
			chk("restarts", k ? 0 : 1, k ? ends : (ends >= 4));
		end
		stop_test;
	end
	initial
	begin
		repeat (60000) @(posedge pclk);
		err_total++;
		stop_test;
	end
endmodule
